/* inc/line_ctrl_pkg.sv */
package line_ctrl_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;
  localparam logic [7:0]  OFS_LOOP_MON   = 8'h14;
  localparam logic [7:0]  OFS_ES_LINE    = 8'h15;
  localparam logic [7:0]  OFS_LINE_OPT   = 8'h16;
  localparam logic [7:0]  RESET_VAL      = 8'h00;
  localparam logic [7:0]  UNMAPPED_VAL   = 8'h00;
  localparam int          BIT_LOCAL_LOOP = 6;
  localparam int          BIT_LI_RESET   = 7;
  localparam int          BIT_ES_ALIGN   = 6;
  localparam int          BIT_ES_RESET   = 5;
  localparam int          CHAN_MSB       = 4;
  localparam int          CHAN_LSB       = 0;
  localparam int          BIT_OPEN_DRAIN = 7;
  localparam int          BIT_DISCONNECT = 6;
  localparam int          BIT_SYNC_MODE  = 5;
  localparam int          BIT_TERM_SEL   = 4;
  localparam int          TX_PRBS_HI     = 3;
  localparam int          TX_PRBS_LO     = 2;
  localparam int          RX_PRBS_HI     = 1;
  localparam int          RX_PRBS_LO     = 0;
  localparam int          CMD_N          = 3;
  localparam int          CMD_LI         = 0;
  localparam int          CMD_ALIGN      = 1;
  localparam int          CMD_ES_RST     = 2;
  localparam int          FRAME_BITS     = 256;
  localparam int          SEP_W          = 9;
  localparam logic [8:0]  HALF_FRAME     = 9'h080;
endpackage : line_ctrl_pkg

/* inc/cmd_edge_if.sv */
interface cmd_edge_if #(parameter int N = 3);
  logic [N-1:0] level;
  logic [N-1:0] pulse;
  modport src (output level, input pulse);
  modport det (input level, output pulse);
endinterface : cmd_edge_if

/* rtl/cmd_edge_detect.sv */
module cmd_edge_detect #(
  parameter int N = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  cmd_edge_if.det  cmd
);
  logic [N-1:0] prev_reg;
  logic [N-1:0] pulse_reg;

  initial begin
    if (N < 1) $error("cmd_edge_detect needs at least one command");
  end

  // Rising edge only; holding the bit high never re-fires
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_reg  <= '0;
      pulse_reg <= '0;
    end else begin
      prev_reg  <= cmd.level;
      pulse_reg <= cmd.level & ~prev_reg;
    end
  end

  assign cmd.pulse = pulse_reg;

  single_pulse_a : assert property (@(posedge clk_sys) disable iff (rst)
    |pulse_reg |=> ~|(pulse_reg & $past(pulse_reg)))
    else $error("command pulse lasted more than one cycle");
endmodule : cmd_edge_detect

/* rtl/e1_loopback_elastic_prbs_control.sv */
// Notes on behaviour
// - Local loopback leaves the outgoing line data unchanged.
// - Local loopback replaces received line data with the transmitted data.
// - Looped data enters the receive path through the jitter attenuator.
// - Rising line reset bit fires one clock recovery and attenuator reset.
// - Rising align bit forces elastic pointers apart by half a frame.
// - Align does nothing when separation is already half a frame or more.
// - An executed align disrupts receive data through the elastic store.
// - Rising elastic reset bit sets depth to one frame, losing data.
// - Bits 4..0 pick the receive channel shown by the monitor, bit 4 MSB.
// - Line option bit 7 selects normal or open-drain line driver.
// - Line option bit 6 sends unframed 1010 instead of normal data.
// - Line option bit 5 sets receiver for E1 or sync signal only.
// - Line option bit 4 selects 120 ohm external or 75 ohm termination.
// - Line option bits 3..2 hold transmit PRBS mode, bit 3 upper.
// - Line option bits 1..0 hold receive PRBS mode, bit 1 upper.
// - Local loopback enable is bit 6 of register at offset 14 hex.
module e1_loopback_elastic_prbs_control (
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  input  wire logic [line_ctrl_pkg::ADDR_W-1:0]  host_addr,
  input  wire logic [line_ctrl_pkg::DATA_W-1:0]  host_wdata,
  input  wire logic                              host_wr,
  input  wire logic                              host_rd,
  output logic      [line_ctrl_pkg::DATA_W-1:0]  host_rdata,
  input  wire logic                              tx_bit_en,
  input  wire logic                              tx_data_pos,
  input  wire logic                              tx_data_neg,
  input  wire logic                              rx_line_pos,
  input  wire logic                              rx_line_neg,
  input  wire logic [line_ctrl_pkg::SEP_W-1:0]   es_separation,
  output logic                                   tx_line_pos,
  output logic                                   tx_line_neg,
  output logic                                   tx_line_oe,
  output logic                                   ja_in_pos,
  output logic                                   ja_in_neg,
  output logic                                   li_reset_pulse,
  output logic                                   es_align_pulse,
  output logic                                   es_data_disrupt,
  output logic                                   es_depth_reset_pulse,
  output logic      [4:0]                        rx_chan_sel,
  output logic                                   driver_open_drain_sel,
  output logic                                   sync_signal_rx_mode,
  output logic                                   rx_termination_sel,
  output logic      [1:0]                        tx_prbs_mode,
  output logic      [1:0]                        rx_prbs_mode
);
  import line_ctrl_pkg::*;

  logic [DATA_W-1:0] loopback_monitor_control_reg;
  logic [DATA_W-1:0] elastic_store_line_reset_control_reg;
  logic [DATA_W-1:0] line_option_prbs_control_reg;
  logic [DATA_W-1:0] host_rdata_reg;
  logic [2:0]        rx_pos_sync_reg;
  logic [2:0]        rx_neg_sync_reg;
  logic              rx_pos_reg;
  logic              rx_neg_reg;
  logic              tx_pos_reg;
  logic              tx_neg_reg;
  logic              tx_oe_reg;
  logic              ja_pos_reg;
  logic              ja_neg_reg;
  logic              pattern_mark_reg;
  logic              pattern_pol_reg;
  logic              li_reset_reg;
  logic              es_align_reg;
  logic              es_disrupt_reg;
  logic              es_depth_reset_reg;
  logic              tx_pos_next;
  logic              tx_neg_next;
  logic              local_loop_enable;
  logic              disconnect_pattern_enable;

  cmd_edge_if #(.N(CMD_N)) cmd ();

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  // Host writes; every bit stores as written
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      loopback_monitor_control_reg         <= RESET_VAL;
      elastic_store_line_reset_control_reg <= RESET_VAL;
      line_option_prbs_control_reg         <= RESET_VAL;
    end else if (host_wr) begin
      if (reg_hit(host_addr, OFS_LOOP_MON)) begin
        loopback_monitor_control_reg <= host_wdata;
      end
      if (reg_hit(host_addr, OFS_ES_LINE)) begin
        elastic_store_line_reset_control_reg <= host_wdata;
      end
      if (reg_hit(host_addr, OFS_LINE_OPT)) begin
        line_option_prbs_control_reg <= host_wdata;
      end
    end
  end

  // Read data lands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      host_rdata_reg <= UNMAPPED_VAL;
    end else if (host_rd) begin
      if (reg_hit(host_addr, OFS_LOOP_MON)) begin
        host_rdata_reg <= loopback_monitor_control_reg;
      end else if (reg_hit(host_addr, OFS_ES_LINE)) begin
        host_rdata_reg <= elastic_store_line_reset_control_reg;
      end else if (reg_hit(host_addr, OFS_LINE_OPT)) begin
        host_rdata_reg <= line_option_prbs_control_reg;
      end else begin
        host_rdata_reg <= UNMAPPED_VAL;
      end
    end
  end

  assign local_loop_enable         = loopback_monitor_control_reg[BIT_LOCAL_LOOP];
  assign disconnect_pattern_enable = line_option_prbs_control_reg[BIT_DISCONNECT];

  // Command bits go through the shared edge detector; one driver for the whole vector
  assign cmd.level = {elastic_store_line_reset_control_reg[BIT_ES_RESET],
                      elastic_store_line_reset_control_reg[BIT_ES_ALIGN],
                      elastic_store_line_reset_control_reg[BIT_LI_RESET]};

  cmd_edge_detect #(.N(CMD_N)) u_edge (
    .clk_sys (clk_sys),
    .rst     (rst),
    .cmd     (cmd)
  );

  // Align is gated by the live pointer separation; a larger gap is left alone
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      li_reset_reg       <= 1'b0;
      es_align_reg       <= 1'b0;
      es_disrupt_reg     <= 1'b0;
      es_depth_reset_reg <= 1'b0;
    end else begin
      li_reset_reg       <= cmd.pulse[CMD_LI];
      es_align_reg       <= cmd.pulse[CMD_ALIGN] && (es_separation < HALF_FRAME);
      es_disrupt_reg     <= (cmd.pulse[CMD_ALIGN] && (es_separation < HALF_FRAME))
                            || cmd.pulse[CMD_ES_RST];
      es_depth_reset_reg <= cmd.pulse[CMD_ES_RST];
    end
  end

  // Line pins are asynchronous; a change counts once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_pos_sync_reg <= '0;
      rx_neg_sync_reg <= '0;
      rx_pos_reg      <= 1'b0;
      rx_neg_reg      <= 1'b0;
    end else begin
      rx_pos_sync_reg <= {rx_pos_sync_reg[1:0], rx_line_pos};
      rx_neg_sync_reg <= {rx_neg_sync_reg[1:0], rx_line_neg};
      if (rx_pos_sync_reg[2] == rx_pos_sync_reg[1]) begin
        rx_pos_reg <= rx_pos_sync_reg[2];
      end
      if (rx_neg_sync_reg[2] == rx_neg_sync_reg[1]) begin
        rx_neg_reg <= rx_neg_sync_reg[2];
      end
    end
  end

  // Unframed 1010 as alternating marks, advanced once per line bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pattern_mark_reg <= 1'b0;
      pattern_pol_reg  <= 1'b0;
    end else if (tx_bit_en) begin
      pattern_mark_reg <= ~pattern_mark_reg;
      if (pattern_mark_reg) begin
        pattern_pol_reg <= ~pattern_pol_reg;
      end
    end
  end

  always_comb begin
    if (disconnect_pattern_enable) begin
      tx_pos_next = pattern_mark_reg & ~pattern_pol_reg;
      tx_neg_next = pattern_mark_reg & pattern_pol_reg;
    end else begin
      tx_pos_next = tx_data_pos;
      tx_neg_next = tx_data_neg;
    end
  end

  // Open drain only drives while a pulse is out; loopback never touches the transmitter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_pos_reg <= 1'b0;
      tx_neg_reg <= 1'b0;
      tx_oe_reg  <= 1'b0;
    end else begin
      tx_pos_reg <= tx_pos_next;
      tx_neg_reg <= tx_neg_next;
      tx_oe_reg  <= line_option_prbs_control_reg[BIT_OPEN_DRAIN]
                    ? (tx_pos_next | tx_neg_next) : 1'b1;
    end
  end

  // Receive feed to the jitter attenuator takes the transmit stream in loopback
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ja_pos_reg <= 1'b0;
      ja_neg_reg <= 1'b0;
    end else if (local_loop_enable) begin
      ja_pos_reg <= tx_pos_next;
      ja_neg_reg <= tx_neg_next;
    end else begin
      ja_pos_reg <= rx_pos_reg;
      ja_neg_reg <= rx_neg_reg;
    end
  end

  assign host_rdata            = host_rdata_reg;
  assign tx_line_pos           = tx_pos_reg;
  assign tx_line_neg           = tx_neg_reg;
  assign tx_line_oe            = tx_oe_reg;
  assign ja_in_pos             = ja_pos_reg;
  assign ja_in_neg             = ja_neg_reg;
  assign li_reset_pulse        = li_reset_reg;
  assign es_align_pulse        = es_align_reg;
  assign es_data_disrupt       = es_disrupt_reg;
  assign es_depth_reset_pulse  = es_depth_reset_reg;
  assign rx_chan_sel           = elastic_store_line_reset_control_reg[CHAN_MSB:CHAN_LSB];
  assign driver_open_drain_sel = line_option_prbs_control_reg[BIT_OPEN_DRAIN];
  assign sync_signal_rx_mode   = line_option_prbs_control_reg[BIT_SYNC_MODE];
  assign rx_termination_sel    = line_option_prbs_control_reg[BIT_TERM_SEL];
  assign tx_prbs_mode          = line_option_prbs_control_reg[TX_PRBS_HI:TX_PRBS_LO];
  assign rx_prbs_mode          = line_option_prbs_control_reg[RX_PRBS_HI:RX_PRBS_LO];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  tx_unaltered_a : assert property (!disconnect_pattern_enable ##1 !disconnect_pattern_enable
    |-> (tx_line_pos == $past(tx_data_pos)) && (tx_line_neg == $past(tx_data_neg)))
    else $error("transmit data altered");
  loop_feed_a : assert property ($past(local_loop_enable)
    |-> (ja_in_pos == $past(tx_pos_next)) && (ja_in_neg == $past(tx_neg_next)))
    else $error("loopback feed wrong");
  loop_through_ja_a : assert property (local_loop_enable && tx_pos_next |=> ja_in_pos)
    else $error("looped mark missing at attenuator");
  li_reset_once_a : assert property (li_reset_pulse |=> !li_reset_pulse [*2])
    else $error("line reset repeated");
  align_edge_a : assert property ($rose(cmd.level[CMD_ALIGN]) && es_separation < HALF_FRAME
    ##1 es_separation < HALF_FRAME |=> es_align_pulse)
    else $error("align not issued");
  align_skip_a : assert property (es_align_pulse |-> $past(es_separation, 1) < HALF_FRAME)
    else $error("align issued with wide gap");
  disrupt_flag_a : assert property (es_align_pulse |-> es_data_disrupt)
    else $error("disruption not flagged");
  es_reset_a : assert property ($rose(cmd.level[CMD_ES_RST]) |-> ##2 es_depth_reset_pulse)
    else $error("elastic reset not issued");
  chan_sel_a : assert property (host_wr && host_addr == OFS_ES_LINE
    |=> rx_chan_sel == $past(host_wdata[CHAN_MSB:CHAN_LSB]))
    else $error("channel select mismatch");
  readback_a : assert property (host_wr && host_addr == OFS_LINE_OPT
    ##1 host_rd && host_addr == OFS_LINE_OPT && !host_wr |=> host_rdata == $past(host_wdata, 2))
    else $error("readback mismatch");

  cov_loop_c    : cover property (local_loop_enable ##1 ja_in_pos);
  cov_align_c   : cover property (es_align_pulse);
  cov_skip_c    : cover property ($rose(cmd.level[CMD_ALIGN]) && es_separation >= HALF_FRAME);
  cov_pattern_c : cover property (disconnect_pattern_enable ##1 tx_line_pos ##[1:20] tx_line_neg);
endmodule : e1_loopback_elastic_prbs_control

/* dv/host_port_model.sv */
module host_port_model (
  input  wire logic                             clk_sys,
  output logic      [line_ctrl_pkg::ADDR_W-1:0] host_addr,
  output logic      [line_ctrl_pkg::DATA_W-1:0] host_wdata,
  output logic                                  host_wr,
  output logic                                  host_rd,
  input  wire logic [line_ctrl_pkg::DATA_W-1:0] host_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import line_ctrl_pkg::*;

  initial begin
    host_addr  = 8'h00;
    host_wdata = 8'h00;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
  end

  // Released lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    host_addr  = a;
    host_wdata = d;
    host_wr    = 1'b1;
    @(negedge clk_sys);
    host_wr    = 1'b0;
    host_addr  = ~a;
    host_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    host_addr = a;
    host_rd   = 1'b1;
    @(negedge clk_sys);
    host_rd   = 1'b0;
    host_addr = ~a;
    d         = host_rdata;
  endtask : rd
endmodule : host_port_model

/* dv/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import line_ctrl_pkg::*;

  logic              clk_sys, rst, host_wr, host_rd, tx_bit_en;
  logic [ADDR_W-1:0] host_addr;
  logic [DATA_W-1:0] host_wdata, host_rdata, rd_val, pv, fv;
  logic              tx_data_pos, tx_data_neg, rx_line_pos, rx_line_neg;
  logic [SEP_W-1:0]  es_separation;
  logic              tx_line_pos, tx_line_neg, tx_line_oe, ja_in_pos, ja_in_neg;
  logic              li_reset_pulse, es_align_pulse, es_data_disrupt, es_depth_reset_pulse;
  logic [4:0]        rx_chan_sel;
  logic              driver_open_drain_sel, sync_signal_rx_mode, rx_termination_sel;
  logic [1:0]        tx_prbs_mode, rx_prbs_mode;
  logic [7:0]        pq[$];
  logic [5:0]        lq[$];
  logic [15:0]       rq[$];
  logic [15:0]       re;
  logic [5:0]        le;
  int                n_fail, checks_done;
  event              rd_ev;

  host_port_model i_host (.clk_sys(clk_sys), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata));

  e1_loopback_elastic_prbs_control i_dut (.clk_sys(clk_sys), .rst(rst),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata), .tx_bit_en(tx_bit_en), .tx_data_pos(tx_data_pos),
    .tx_data_neg(tx_data_neg), .rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg),
    .es_separation(es_separation), .tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg),
    .tx_line_oe(tx_line_oe), .ja_in_pos(ja_in_pos), .ja_in_neg(ja_in_neg),
    .li_reset_pulse(li_reset_pulse), .es_align_pulse(es_align_pulse),
    .es_data_disrupt(es_data_disrupt), .es_depth_reset_pulse(es_depth_reset_pulse),
    .rx_chan_sel(rx_chan_sel), .driver_open_drain_sel(driver_open_drain_sel),
    .sync_signal_rx_mode(sync_signal_rx_mode), .rx_termination_sel(rx_termination_sel),
    .tx_prbs_mode(tx_prbs_mode), .rx_prbs_mode(rx_prbs_mode));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (pq.size() + rq.size() != 0) begin
      n_fail++;
      $display("BAD t=%0t pulses never seen", $time);
    end
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rq.push_back({a, e});
    i_host.rd(a, rd_val);
    -> rd_ev;
  endtask : rd_chk

  // Receive positive pin carries the inverse of transmit positive so a leak through loopback shows; negative pin is random
  task automatic line_run(input int n, input logic lp, input logic od);
    logic p, q;
    repeat (2) @(negedge clk_sys);
    repeat (n) begin
      @(negedge clk_sys);
      p           = 1'($urandom);
      q           = p ? 1'b0 : 1'($urandom);
      tx_data_pos = p;
      tx_data_neg = q;
      rx_line_pos = ~p;
      rx_line_neg = 1'($urandom);
      tx_bit_en   = 1'($urandom);
      lq.push_back({lp, od ? (p | q) : 1'b1, p, q, p, q});
    end
  endtask : line_run

  always @(rd_ev) begin
    re = rq.pop_front();
    check(rd_val, re[7:0]);
    if (re[15:8] == OFS_LINE_OPT)
      fv = {driver_open_drain_sel, re[6], sync_signal_rx_mode, rx_termination_sel,
            tx_prbs_mode, rx_prbs_mode};
    else if (re[15:8] == OFS_ES_LINE)
      fv = {re[7:5], rx_chan_sel};
    else
      fv = re[7:0];
    check(fv, re[7:0]);
  end

  always @(posedge clk_sys) begin
    #2;
    pv = {4'h0, li_reset_pulse, es_align_pulse, es_data_disrupt, es_depth_reset_pulse};
    if (rst === 1'b0 && pv !== 8'h00)
      check(pv, (pq.size() > 0) ? pq.pop_front() : 8'h00);
    if (lq.size() > 0) begin
      le = lq.pop_front();
      check({2'b00, le[5], tx_line_oe, tx_line_pos, tx_line_neg,
             le[5] ? {ja_in_pos, ja_in_neg} : le[1:0]}, {2'b00, le});
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #300us;
    n_fail++;
    $display("BAD t=%0t run hung", $time);
    stop_test();
  end

  initial begin : main
    logic [7:0] ofs[3] = '{OFS_LOOP_MON, OFS_ES_LINE, OFS_LINE_OPT};
    logic [7:0] cmds[4] = '{8'h40, 8'h00, 8'h40, 8'hE0};
    logic [8:0] seps[4] = '{9'h07F, 9'h000, 9'h080, 9'h000};
    logic [7:0] v, r, prev;
    logic       ex;
    rst = 1'b1;
    {tx_bit_en, tx_data_pos, tx_data_neg, rx_line_pos, rx_line_neg} = 5'b00000;
    es_separation = 9'h000;
    n_fail = 0;
    checks_done = 0;
    void'($urandom(32'h8a6c));
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    foreach (ofs[i]) rd_chk(ofs[i], RESET_VAL);
    repeat (4) foreach (ofs[i]) begin
      // Command bits kept low here; the edge test below owns them
      v = 8'($urandom) & ((ofs[i] == OFS_ES_LINE) ? 8'h1F : 8'hFF);
      i_host.wr(ofs[i], v);
      i_host.wr(8'h20, ~v);
      rd_chk(ofs[i], v);
      rd_chk(8'h20, UNMAPPED_VAL);
    end
    i_host.wr(OFS_ES_LINE, 8'h00);
    prev = 8'h00;
    // Commands only issued once the clock has run long after reset
    for (int k = 0; k < 20; k++) begin
      v = (k < 4) ? cmds[k] : 8'($urandom);
      @(negedge clk_sys);
      es_separation = (k < 4) ? seps[k] : 9'($urandom % 256);
      r  = v & ~prev;
      ex = r[BIT_ES_ALIGN] && (es_separation < HALF_FRAME);
      if (r[7:5] != 3'b000 && (r[7] || r[5] || ex))
        pq.push_back({4'h0, r[BIT_LI_RESET], ex, ex | r[BIT_ES_RESET], r[BIT_ES_RESET]});
      i_host.wr(OFS_ES_LINE, v);
      repeat (4) @(negedge clk_sys);
      prev = v;
    end
    rd_chk(OFS_ES_LINE, prev);
    i_host.wr(OFS_LINE_OPT, 8'h00);
    i_host.wr(OFS_LOOP_MON, 8'h00);
    line_run(40, 1'b0, 1'b0);
    i_host.wr(OFS_LOOP_MON, 8'h40);
    line_run(40, 1'b1, 1'b0);
    i_host.wr(OFS_LINE_OPT, 8'h80);
    line_run(40, 1'b1, 1'b1);
    i_host.wr(OFS_LINE_OPT, 8'h20);
    i_host.wr(OFS_LOOP_MON, 8'hBF);
    line_run(40, 1'b0, 1'b0);
    // Disconnect pattern: marks on alternate bits, each mark of opposite polarity
    i_host.wr(OFS_LINE_OPT, 8'h40);
    tx_bit_en = 1'b1;
    repeat (3) @(negedge clk_sys);
    prev = {6'h00, tx_line_pos, tx_line_neg};
    r    = 8'h00;
    repeat (8) begin
      @(negedge clk_sys);
      v = {6'h00, tx_line_pos, tx_line_neg};
      check({7'h00, |v}, {7'h00, ~|prev});
      if (|v && |r) check(v, ~r & 8'h03);
      if (|v) r = v;
      prev = v;
    end
    tx_bit_en = 1'b0;
    repeat (8) @(negedge clk_sys);
    stop_test();
  end
endmodule : testbench
